// ==== core/demod_regs_defs.svh ====
// offsets, field positions, reset values and timing counts of the register bank
`ifndef DEMOD_REGS_DEFS_SVH
`define DEMOD_REGS_DEFS_SVH
// slave address: fixed bits, strap-driven bits
`define ADDR_BASE 7'h42
`define STD_SLAVE_ADDR 7'h43
`define ADDR_A3_BIT 3
`define ADDR_A0_BIT 0
// register index values (index bits 1:0)
`define IDX_SWITCH 2'h0
`define IDX_ADJUST 2'h1
`define IDX_IFSEL 2'h2
`define IDX_DONE 2'h3
// reset values
`define SWITCH_RST 8'hd6
`define ADJUST_RST 8'h30
`define IFSEL_RST_OPEN 8'h04
`define IFSEL_RST_FIT 8'h00
// switching register fields
`define SW_PORT_TWO 7
`define SW_PORT_ONE 6
`define SW_MUTE 5
`define SW_MOD_HI 4
`define SW_MOD_LO 3
`define SW_CARRIER 2
`define SW_AUTOMUTE 1
`define SW_TRAP 0
// adjust register fields
`define ADJ_GAIN_CUT 7
`define ADJ_TC_SEL 6
`define ADJ_DEEMPH 5
`define ADJ_TOP_HI 4
// frequency/data register fields
`define IFS_AGC_FEAT 7
`define IFS_LGATE 6
`define IFS_MIN_GAIN 5
`define IFS_VIF_HI 4
`define IFS_VIF_LO 2
`define IFS_SIF_HI 1
// serial bus timing: fastest clock and the clk cycles in one of its periods
`define SCL_MAX_KHZ 400
`define CLK_MHZ 25
`define SCL_PERIOD_CYC ((`CLK_MHZ * 1000) / `SCL_MAX_KHZ)
// cycles after reset release before straps are taken (two sync stages plus one)
`define STRAP_WAIT 2'h3
// bits per byte on the serial bus
`define BYTE_BITS 4'h8
`define LAST_BIT 3'h7
`endif

// ==== core/demod_regs_pkg.sv ====
// types shared by the register bank and its users
package demod_regs_pkg;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_ADDR = 4'b0001,
    ST_ADDR_ACK = 4'b0010,
    ST_INDEX = 4'b0011,
    ST_INDEX_ACK = 4'b0100,
    ST_DATA = 4'b0101,
    ST_DATA_ACK = 4'b0110,
    ST_READ = 4'b0111,
    ST_READ_ACK = 4'b1000
  } slave_state_e;

  typedef enum logic [1:0] {
    AGC_NORMAL = 2'b00,
    AGC_MIN_GAIN = 2'b01,
    AGC_OUT_PORT_TWO = 2'b10,
    AGC_EXT_IN_PORT_ONE = 2'b11
  } agc_mode_e;

  // analog-side status sources (asynchronous to clk)
  typedef struct packed {
    logic freq_window_flag;
    logic input_level_flag;
    logic sound_carrier_found;
    logic [3:0] freq_offset_code;
  } analog_status_s;

  // decoded control towards the analog blocks
  typedef struct packed {
    logic out_port_two;
    logic out_port_one;
    logic forced_mute;
    logic [1:0] modulation;
    logic split_sound_mode;
    logic auto_mute_en;
    logic trap_bypass;
    logic audio_gain_cut;
    logic deemph_tc_sel;
    logic deemph_en;
    logic [4:0] takeover_point;
    logic agc_port_feature;
    logic l_gating_sel;
    logic min_gain_sel;
    logic [2:0] vision_if_sel;
    logic [1:0] sound_if_sel;
    agc_mode_e agc_mode;
  } ctrl_out_s;

  // whole state of the register bank
  typedef struct packed {
    logic scl_prev_r;
    logic sda_prev_r;
    logic strap_ok_r;
    logic [1:0] strap_cnt_r;
    logic addr_a0_r;
    logic addr_a3_r;
    slave_state_e state_r;
    logic [3:0] bit_cnt_r;
    logic [7:0] shift_r;
    logic read_dir_r;
    logic acked_r;
    logic [1:0] register_index_r;
    logic sda_oe_r;
    logic power_up_flag_r;
    logic [7:0] tv_switching_ctrl_r;
    logic [7:0] adjust_ctrl_r;
    logic [7:0] if_select_ctrl_r;
    agc_mode_e agc_mode_r;
  } bank_state_s;
endpackage : demod_regs_pkg

// ==== core/if_demod_serial_control_regs.sv ====
// serial-bus slave register bank of the IF demodulator
// Behaviour
// - answer only to one of 0x43, 0x42, 0x4B, 0x4A; 0x43 is standard
// - address bit A0 from sound-out strap, A3 from sound-input straps
// - bus runs correctly up to 400 kHz serial clock; master stays below
// - status byte repeats while master acks; master ends with nack, stop
// - status bit 7 high while oscillator is inside the 1.6 MHz window
// - status bit 6 shows high input level, bit 5 shows carrier found
// - status bits 4:1 give frequency offset code in 25 kHz steps
// - status bit 0 set by power-on or supply failure, cleared by read
// - second write byte is index; bits 1:0 pick switching, adjust, frequency
// - index bits 6 to 2 are ignored when decoding
// - further data bytes go to the next register in fixed order
// - switching bits 7 and 6 drive ports two and one
// - switching bit 5 forces mute, bit 1 enables auto mute
// - switching bits 4:3 select modulation: 00 positive, 10 negative
// - switching bit 2 selects split sound, bit 0 bypasses trap
// - adjust bit 7 cuts gain, bit 6 picks time constant, bit 5 de-emphasis
// - adjust bits 4:0 set takeover point, offset binary in 1 dB steps
// - frequency bit 6 selects L-standard gating level
// - with switching bit 3 low, bits 7 and 5 choose the AGC mode
// - frequency bits 4:2 select the vision IF
// - frequency bits 1:0 select the second sound IF
// - reset loads 0xD6, 0x30, and 0x00 or 0x04 by strap
`timescale 1ns/1ps
`include "demod_regs_defs.svh"
module if_demod_serial_control_regs (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic scl_pin,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic sound_out_addr_pin,
  input wire logic sound_input_pin_a,
  input wire logic sound_input_pin_b,
  input wire logic supply_fail,
  input wire demod_regs_pkg::analog_status_s demod_status_in,
  output logic power_up_flag,
  output demod_regs_pkg::ctrl_out_s ctrl
);
  import demod_regs_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // synchronised pins

  localparam int SYNC_W = 13;
  logic [SYNC_W-1:0] pins_raw;
  logic [SYNC_W-1:0] pins_s;
  logic scl_s;
  logic sda_s;
  logic sio_s;
  logic sif_a_s;
  logic sif_b_s;
  logic supply_fail_s;
  analog_status_s stat_s;

  // bus lines idle high, straps idle open (high)
  assign pins_raw = {scl_pin, sda_in, sound_out_addr_pin, sound_input_pin_a,
                     sound_input_pin_b, supply_fail, demod_status_in};

  sync_two_ff #(
    .WIDTH(SYNC_W),
    .RST_VAL(13'h1f00)
  ) u_pin_sync (
    .clk(clk),
    .reset_n(reset_n),
    .d(pins_raw),
    .q(pins_s)
  );

  // split the synchronised vector back into named lines
  assign {scl_s, sda_s, sio_s, sif_a_s, sif_b_s, supply_fail_s, stat_s} = pins_s;

  //////////////////////////////////////////////////////////////////////////////
  // state

  bank_state_s st_r;
  bank_state_s st_nxt;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic [6:0] my_addr;
  logic [7:0] status_byte;
  logic bit_in;
  logic byte_done;
  logic addr_match;

  // edge and condition detection; a few cycles of lag is nothing beside a 400 kHz bit
  assign scl_rise = scl_s & ~st_r.scl_prev_r;
  assign scl_fall = ~scl_s & st_r.scl_prev_r;
  assign bus_start = scl_s & st_r.scl_prev_r & st_r.sda_prev_r & ~sda_s;
  assign bus_stop = scl_s & st_r.scl_prev_r & ~st_r.sda_prev_r & sda_s;

  // byte framing: a bit is taken on a rise, the byte is done at the fall after eight
  assign bit_in = scl_rise & (st_r.bit_cnt_r != `BYTE_BITS);
  assign byte_done = scl_fall & (st_r.bit_cnt_r == `BYTE_BITS);
  assign addr_match = (st_r.shift_r[7:1] == my_addr);

  // slave address from the two captured strap bits
  always_comb begin
    my_addr = `ADDR_BASE;
    my_addr[`ADDR_A3_BIT] = st_r.addr_a3_r;
    my_addr[`ADDR_A0_BIT] = st_r.addr_a0_r;
  end

  // live status byte; analog flags pass straight through their sync stages
  assign status_byte = {stat_s.freq_window_flag,
                        stat_s.input_level_flag,
                        stat_s.sound_carrier_found,
                        stat_s.freq_offset_code,
                        st_r.power_up_flag_r};

  //////////////////////////////////////////////////////////////////////////////
  // next-state logic

  always_comb begin
    st_nxt = st_r;
    // line history for edge and condition detection
    st_nxt.scl_prev_r = scl_s;
    st_nxt.sda_prev_r = sda_s;

    // straps are taken once the sync stages hold real pin levels
    if (!st_r.strap_ok_r) begin
      st_nxt.strap_cnt_r = st_r.strap_cnt_r + 2'h1;
      if (st_r.strap_cnt_r == `STRAP_WAIT) begin
        st_nxt.strap_ok_r = 1'b1;
        st_nxt.addr_a0_r = sio_s; // resistor pulls low: A0 cleared
        st_nxt.addr_a3_r = ~sif_a_s & ~sif_b_s; // resistor on both: A3 set
        st_nxt.if_select_ctrl_r = sio_s ? `IFSEL_RST_OPEN : `IFSEL_RST_FIT;
      end
    end else if (bus_stop) begin
      // stop ends any transfer and frees the data line
      st_nxt.state_r = ST_IDLE;
      st_nxt.sda_oe_r = 1'b0;
    end else if (bus_start) begin
      // start or repeated start: expect an address byte
      st_nxt.state_r = ST_ADDR;
      st_nxt.bit_cnt_r = 4'h0;
      st_nxt.sda_oe_r = 1'b0;
    end else begin
      case (st_r.state_r)
        // bus free or not addressed: keep off the data line
        ST_IDLE: begin
          st_nxt.sda_oe_r = 1'b0;
        end

        // receiving a byte: sample on rising clock, act on falling after eight
        ST_ADDR, ST_INDEX, ST_DATA: begin
          if (bit_in) begin
            st_nxt.shift_r = {st_r.shift_r[6:0], sda_s};
            st_nxt.bit_cnt_r = st_r.bit_cnt_r + 4'h1;
          end else if (byte_done) begin
            st_nxt.bit_cnt_r = 4'h0;
            if (st_r.state_r == ST_ADDR) begin
              if (addr_match) begin
                st_nxt.sda_oe_r = 1'b1;
                st_nxt.read_dir_r = st_r.shift_r[0];
                st_nxt.state_r = ST_ADDR_ACK;
              end else begin
                st_nxt.state_r = ST_IDLE; // not ours: stay off the bus
              end
            end else if (st_r.state_r == ST_INDEX) begin
              // only bits 1:0 steer; bit 7 is never sent set
              st_nxt.register_index_r = st_r.shift_r[1:0];
              st_nxt.sda_oe_r = 1'b1;
              st_nxt.state_r = ST_INDEX_ACK;
            end else begin
              // store at index and step on; past the last, discard
              case (st_r.register_index_r)
                `IDX_SWITCH: begin
                  st_nxt.tv_switching_ctrl_r = st_r.shift_r;
                  st_nxt.register_index_r = `IDX_ADJUST;
                end
                `IDX_ADJUST: begin
                  st_nxt.adjust_ctrl_r = st_r.shift_r;
                  st_nxt.register_index_r = `IDX_IFSEL;
                end
                `IDX_IFSEL: begin
                  st_nxt.if_select_ctrl_r = st_r.shift_r;
                  st_nxt.register_index_r = `IDX_DONE;
                end
                default: begin
                  st_nxt.register_index_r = `IDX_DONE;
                end
              endcase
              st_nxt.sda_oe_r = 1'b1; // every data byte is acked
              st_nxt.state_r = ST_DATA_ACK;
            end
          end
        end

        // holding ack low through one clock pulse
        ST_ADDR_ACK, ST_INDEX_ACK, ST_DATA_ACK: begin
          if (scl_fall) begin
            st_nxt.bit_cnt_r = 4'h0;
            if (st_r.state_r == ST_ADDR_ACK && st_r.read_dir_r) begin
              st_nxt.shift_r = status_byte;
              st_nxt.sda_oe_r = ~status_byte[7];
              st_nxt.state_r = ST_READ;
            end else begin
              st_nxt.sda_oe_r = 1'b0;
              st_nxt.state_r = (st_r.state_r == ST_ADDR_ACK) ? ST_INDEX : ST_DATA;
            end
          end
        end

        // shifting the status byte out, msb first, a bit per falling edge
        ST_READ: begin
          if (scl_fall) begin
            // the eighth fall hands the line back for the master's answer
            if (st_r.bit_cnt_r[2:0] == `LAST_BIT) begin
              st_nxt.sda_oe_r = 1'b0;
              st_nxt.acked_r = 1'b0;
              st_nxt.state_r = ST_READ_ACK;
            end else begin
              st_nxt.shift_r = {st_r.shift_r[6:0], 1'b0};
              st_nxt.sda_oe_r = ~st_r.shift_r[6];
              st_nxt.bit_cnt_r = st_r.bit_cnt_r + 4'h1;
            end
          end
        end

        // master ack repeats the status byte; nack ends the read
        ST_READ_ACK: begin
          if (scl_rise) begin
            // cleared at the answer slot, so a final nack still counts as read
            st_nxt.power_up_flag_r = 1'b0; // byte fully read
            if (sda_s) begin
              st_nxt.state_r = ST_IDLE;
            end else begin
              st_nxt.acked_r = 1'b1;
            end
          end else if (scl_fall && st_r.acked_r) begin
            st_nxt.bit_cnt_r = 4'h0;
            st_nxt.shift_r = status_byte;
            st_nxt.sda_oe_r = ~status_byte[7];
            st_nxt.state_r = ST_READ;
          end
        end

        // unused state codes fall back to idle
        default: begin
          st_nxt.state_r = ST_IDLE;
          st_nxt.sda_oe_r = 1'b0;
        end
      endcase
    end

    // supply failure sets the flag and wins over a read clear
    if (supply_fail_s) begin
      st_nxt.power_up_flag_r = 1'b1;
    end

    // AGC and port function from the new register values
    if (st_nxt.tv_switching_ctrl_r[`SW_MOD_LO]) begin
      st_nxt.agc_mode_r = AGC_NORMAL;
    end else begin
      case ({st_nxt.if_select_ctrl_r[`IFS_AGC_FEAT], st_nxt.if_select_ctrl_r[`IFS_MIN_GAIN]})
        2'b00: begin
          st_nxt.agc_mode_r = AGC_NORMAL; // both pins keep their port function
        end
        2'b01: begin
          st_nxt.agc_mode_r = AGC_MIN_GAIN;
        end
        2'b10: begin
          st_nxt.agc_mode_r = AGC_OUT_PORT_TWO; // port two carries the agc output
        end
        default: begin
          st_nxt.agc_mode_r = AGC_EXT_IN_PORT_ONE; // port one takes external agc
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // state register

  // reset loads defaults and sets the power-up flag
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      // bus side starts from an idle, released bus
      st_r.scl_prev_r <= 1'b1;
      st_r.sda_prev_r <= 1'b1;
      st_r.state_r <= ST_IDLE;
      st_r.bit_cnt_r <= 4'h0;
      st_r.shift_r <= 8'h00;
      st_r.read_dir_r <= 1'b0;
      st_r.acked_r <= 1'b0;
      st_r.register_index_r <= `IDX_SWITCH;
      st_r.sda_oe_r <= 1'b0;

      // straps not yet taken: address held at the standard one, bus ignored meanwhile
      st_r.strap_ok_r <= 1'b0;
      st_r.strap_cnt_r <= 2'h0;
      st_r.addr_a0_r <= 1'b1;
      st_r.addr_a3_r <= 1'b0;

      // control defaults, power-up flag set
      st_r.power_up_flag_r <= 1'b1;
      st_r.tv_switching_ctrl_r <= `SWITCH_RST;
      st_r.adjust_ctrl_r <= `ADJUST_RST;
      st_r.if_select_ctrl_r <= `IFSEL_RST_OPEN;
      st_r.agc_mode_r <= AGC_NORMAL;
    end else begin
      st_r <= st_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs

  // open-drain data line: only ever pulled low
  assign sda_out = 1'b0;
  assign sda_oe = st_r.sda_oe_r;

  // status bit 0 also leaves as a plain level
  assign power_up_flag = st_r.power_up_flag_r;

  // switching register fields
  assign ctrl.out_port_two = st_r.tv_switching_ctrl_r[`SW_PORT_TWO];
  assign ctrl.out_port_one = st_r.tv_switching_ctrl_r[`SW_PORT_ONE];
  assign ctrl.forced_mute = st_r.tv_switching_ctrl_r[`SW_MUTE];
  assign ctrl.modulation = st_r.tv_switching_ctrl_r[`SW_MOD_HI:`SW_MOD_LO];
  assign ctrl.split_sound_mode = st_r.tv_switching_ctrl_r[`SW_CARRIER];
  assign ctrl.auto_mute_en = st_r.tv_switching_ctrl_r[`SW_AUTOMUTE];
  assign ctrl.trap_bypass = st_r.tv_switching_ctrl_r[`SW_TRAP];

  // adjust register fields
  assign ctrl.audio_gain_cut = st_r.adjust_ctrl_r[`ADJ_GAIN_CUT];
  assign ctrl.deemph_tc_sel = st_r.adjust_ctrl_r[`ADJ_TC_SEL];
  assign ctrl.deemph_en = st_r.adjust_ctrl_r[`ADJ_DEEMPH];
  assign ctrl.takeover_point = st_r.adjust_ctrl_r[`ADJ_TOP_HI:0];

  // frequency/data register fields
  assign ctrl.agc_port_feature = st_r.if_select_ctrl_r[`IFS_AGC_FEAT];
  assign ctrl.l_gating_sel = st_r.if_select_ctrl_r[`IFS_LGATE];
  assign ctrl.min_gain_sel = st_r.if_select_ctrl_r[`IFS_MIN_GAIN];
  assign ctrl.vision_if_sel = st_r.if_select_ctrl_r[`IFS_VIF_HI:`IFS_VIF_LO];
  assign ctrl.sound_if_sel = st_r.if_select_ctrl_r[`IFS_SIF_HI:0];
  assign ctrl.agc_mode = st_r.agc_mode_r;
endmodule : if_demod_serial_control_regs

// ==== core/sync_two_ff.sv ====
// two flip-flop synchroniser for a group of asynchronous inputs
`timescale 1ns/1ps
module sync_two_ff #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  typedef struct packed {
    logic [WIDTH-1:0] s1_r;
    logic [WIDTH-1:0] s2_r;
  } sync_state_s;

  sync_state_s st_r;
  sync_state_s st_nxt;

  // first stage feeds only the second
  always_comb begin
    st_nxt = st_r;
    st_nxt.s1_r = d;
    st_nxt.s2_r = st_r.s1_r;
  end

  // register with synchronous reset
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st_r <= {RST_VAL, RST_VAL};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q = st_r.s2_r;
endmodule : sync_two_ff

// ==== dv/bus_master_model.sv ====
// two-wire bus master that drives the register bank
`timescale 1ns/1ps
module bus_master_model (
  input wire logic clk,
  input wire logic sda_line,
  output logic scl,
  output logic sda_low
);
  localparam int QTR = 16; // 2.56 us bit, below the 400 kHz ceiling
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  ////////////////////////////////////////
  // quarter bit, moving just after a falling clk edge
  task automatic wq();
    repeat (QTR) @(negedge clk);
  endtask : wq
  // start or repeated start: data falls while clock high
  task automatic start();
    sda_low = 1'b0;
    wq();
    scl = 1'b1;
    wq();
    sda_low = 1'b1;
    wq();
    scl = 1'b0;
    wq();
  endtask : start
  // stop: data rises while clock high
  task automatic stop();
    sda_low = 1'b1;
    wq();
    scl = 1'b1;
    wq();
    sda_low = 1'b0;
    wq();
  endtask : stop
  // one bit; data held steady while clock is high
  task automatic bit_io(input logic tx, output logic rx);
    sda_low = ~tx;
    wq();
    scl = 1'b1;
    wq();
    rx = sda_line;
    wq();
    scl = 1'b0;
    wq();
  endtask : bit_io
  // byte msb first, then the acknowledge bit given by mack
  task automatic xfer(input logic [7:0] tx, input logic mack, output logic [7:0] rx,
      output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
    bit_io(mack, a);
    ack = ~a;
  endtask : xfer
endmodule : bus_master_model

// ==== dv/demod_regs_asserts.sv ====
// port assertions of the serial control register bank
`timescale 1ns/1ps
module demod_regs_asserts (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic scl_pin,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic sound_out_addr_pin,
  input wire logic sound_input_pin_a,
  input wire logic sound_input_pin_b,
  input wire logic supply_fail,
  input wire demod_regs_pkg::analog_status_s demod_status_in,
  input wire logic power_up_flag,
  input wire demod_regs_pkg::ctrl_out_s ctrl
);
  import demod_regs_pkg::*;
  logic [3:0] up_cnt_r;
  default clocking cb @(posedge clk); endclocking
  ////////////////////////////////////////
  // cycles since reset release, saturating; straps settle early on
  always_ff @(posedge clk) begin
    if (!reset_n) up_cnt_r <= 4'h0;
    else if (up_cnt_r != 4'hf) up_cnt_r <= up_cnt_r + 4'h1;
  end
  sequence scl_quiet;
    $stable(scl_pin) [*8];
  endsequence
  sequence oe_held;
    sda_oe [*8];
  endsequence
  reset_ctrl_a: assert property (
    disable iff (1'b0) !reset_n |=> ctrl.takeover_point == 5'h10 &&
      ctrl.modulation == 2'h2 && ctrl.vision_if_sel == 3'h1 && ctrl.out_port_two)
    else $error("control fields not at reset values");
  reset_flag_a: assert property (disable iff (1'b0) !reset_n |=> power_up_flag)
    else $error("power-up flag clear after reset");
  reset_oe_a: assert property (disable iff (1'b0) !reset_n |=> !sda_oe)
    else $error("data line pulled during reset");
  supply_flag_a: assert property (
    disable iff (!reset_n) supply_fail [*5] |-> power_up_flag)
    else $error("supply failure did not set power-up flag");
  agc_forced_a: assert property (
    disable iff (!reset_n) ctrl.modulation[0] |-> ctrl.agc_mode == AGC_NORMAL)
    else $error("agc mode not normal with modulation bit 3 set");
  agc_decode_a: assert property (
    disable iff (!reset_n) !ctrl.modulation[0] |->
      ctrl.agc_mode == agc_mode_e'({ctrl.agc_port_feature, ctrl.min_gain_sel}))
    else $error("agc mode does not follow its two bits");
  ctrl_quiet_a: assert property (
    disable iff (!reset_n) scl_quiet |-> $stable(ctrl) || up_cnt_r != 4'hf)
    else $error("control changed without bus clock activity");
  oe_edge_a: assert property (disable iff (!reset_n) $changed(sda_oe) |-> !scl_pin)
    else $error("data line changed while bus clock high");
  oe_hold_a: assert property (disable iff (!reset_n) $rose(sda_oe) |-> oe_held)
    else $error("pulled bit not held");
endmodule : demod_regs_asserts
bind if_demod_serial_control_regs demod_regs_asserts u_chk (.clk, .reset_n, .scl_pin,
  .sda_in, .sda_out, .sda_oe, .sound_out_addr_pin, .sound_input_pin_a,
  .sound_input_pin_b, .supply_fail, .demod_status_in, .power_up_flag, .ctrl);

// ==== dv/if_demod_serial_control_regs_tb.sv ====
// testbench of the serial control register bank
`timescale 1ns/1ps
module if_demod_serial_control_regs_tb;
  import demod_regs_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic sound_out_addr_pin = 1'b1;
  logic sound_input_pin_a = 1'b1;
  logic sound_input_pin_b = 1'b1;
  logic supply_fail = 1'b0;
  analog_status_s status_in = '0;
  wire scl;
  wire sda_low;
  wire sda_line;
  wire sda_out;
  wire sda_oe;
  wire power_up_flag;
  ctrl_out_s ctrl;
  wire [23:0] regs;
  int n_fail = 0;
  int checked = 0;
  int cyc = 0;
  always #20 clk = ~clk;
  // pulled-up wired-and data line
  assign sda_line = (sda_oe ? sda_out : 1'b1) & ~sda_low;
  assign regs = {ctrl.out_port_two, ctrl.out_port_one, ctrl.forced_mute, ctrl.modulation,
    ctrl.split_sound_mode, ctrl.auto_mute_en, ctrl.trap_bypass, ctrl.audio_gain_cut,
    ctrl.deemph_tc_sel, ctrl.deemph_en, ctrl.takeover_point, ctrl.agc_port_feature,
    ctrl.l_gating_sel, ctrl.min_gain_sel, ctrl.vision_if_sel, ctrl.sound_if_sel};
  if_demod_serial_control_regs dut (.clk(clk), .reset_n(reset_n), .scl_pin(scl),
    .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
    .sound_out_addr_pin(sound_out_addr_pin), .sound_input_pin_a(sound_input_pin_a),
    .sound_input_pin_b(sound_input_pin_b), .supply_fail(supply_fail),
    .demod_status_in(status_in), .power_up_flag(power_up_flag), .ctrl(ctrl));
  bus_master_model m (.clk(clk), .sda_line(sda_line), .scl(scl), .sda_low(sda_low));
  ////////////////////////////////////////
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // write: address, index, n data bytes, stop; index bit 7 kept clear
  task automatic wr(input logic [6:0] a, input logic [7:0] idx, input logic [31:0] d,
      input int n, input logic ok);
    logic [7:0] rx;
    logic ack;
    m.start();
    m.xfer({a, 1'b0}, 1'b1, rx, ack);
    chk("address ack", 24'(ok), 24'(ack));
    if (ok) begin
      m.xfer(idx, 1'b1, rx, ack);
      chk("index ack", 24'h1, 24'(ack));
      for (int i = 0; i < n; i++) begin
        m.xfer(d[31-8*i -: 8], 1'b1, rx, ack);
        chk("data ack", 24'h1, 24'(ack));
      end
    end
    m.stop();
  endtask : wr
  // read two status bytes, acking the first and refusing the second
  task automatic rd(input logic [6:0] a, input logic [7:0] e0, input logic [7:0] e1);
    logic [7:0] rx;
    logic ack;
    m.start();
    m.xfer({a, 1'b1}, 1'b1, rx, ack);
    chk("read address ack", 24'h1, 24'(ack));
    m.xfer(8'hff, 1'b0, rx, ack);
    chk("status byte 0", 24'(e0), 24'(rx));
    m.xfer(8'hff, 1'b1, rx, ack);
    chk("status byte 1", 24'(e1), 24'(rx));
    m.stop();
  endtask : rd
  task automatic t_defaults();
    chk("reset regs", 24'hd6_3004, regs);
    chk("power-up flag", 24'h1, 24'(power_up_flag));
    $display("test defaults done");
  endtask : t_defaults
  task automatic t_status();
    status_in = 7'h5a;
    rd(7'h43, 8'hb5, 8'hb4);
    status_in = 7'h25;
    rd(7'h43, 8'h4a, 8'h4a);
    chk("power-up flag", 24'h0, 24'(power_up_flag));
    $display("test status done");
  endtask : t_status
  task automatic t_write();
    wr(7'h43, 8'h00, 32'h2a55_3cff, 4, 1'b1);
    chk("regs incremented", 24'h2a_553c, regs);
    wr(7'h43, 8'h7d, 32'h1f00_0000, 1, 1'b1);
    chk("regs masked index", 24'h2a_1f3c, regs);
    wr(7'h43, 8'h03, 32'h5a00_0000, 1, 1'b1);
    chk("regs index three", 24'h2a_1f3c, regs);
    $display("test write done");
  endtask : t_write
  task automatic t_agc();
    logic [7:0] e;
    logic [6:0] bad [3] = '{7'h42, 7'h4b, 7'h4a};
    for (int k = 0; k < 4; k++) begin
      e = {k[1], k[0], k[0], 3'h3, k[1], k[0]}; // gating and sound IF vary too
      wr(7'h43, 8'h00, {8'hc0, 8'h30, e, 8'h00}, 3, 1'b1); // ports released first
      chk("regs agc", {8'hc0, 8'h30, e}, regs);
      chk("agc mode", 24'(k), 24'(ctrl.agc_mode));
    end
    wr(7'h43, 8'h00, 32'hc800_0000, 1, 1'b1);
    chk("agc mode forced", 24'(AGC_NORMAL), 24'(ctrl.agc_mode));
    for (int j = 0; j < 3; j++) wr(bad[j], 8'h00, 32'h0, 1, 1'b0);
    chk("regs after foreign address", 24'hc8_30ef, regs);
    $display("test agc done");
  endtask : t_agc
  task automatic t_straps();
    sound_out_addr_pin = 1'b0;
    sound_input_pin_a = 1'b0;
    sound_input_pin_b = 1'b0;
    reset_n = 1'b0;
    repeat (6) @(negedge clk);
    reset_n = 1'b1;
    repeat (12) @(negedge clk);
    chk("strap regs", 24'hd6_3000, regs);
    wr(7'h43, 8'h00, 32'h0, 1, 1'b0);
    status_in = 7'h00;
    rd(7'h4a, 8'h01, 8'h00);
    supply_fail = 1'b1;
    repeat (8) @(negedge clk);
    supply_fail = 1'b0;
    chk("supply flag", 24'h1, 24'(power_up_flag));
    $display("test straps done");
  endtask : t_straps
  // main sequence
  initial begin
    repeat (6) @(negedge clk);
    reset_n = 1'b1;
    repeat (12) @(negedge clk);
    t_defaults();
    t_status();
    t_write();
    t_agc();
    t_straps();
    tally_and_finish();
  end
  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      n_fail++;
      tally_and_finish();
    end
  end
endmodule : if_demod_serial_control_regs_tb
